// [hw/b2s_cfg_if.sv]
// Configuration fields passed from the register bank to the
// target selector. Assumes both ends share clk_sys_i.
`timescale 1ns/1ns
`default_nettype none

interface b2s_cfg_if;
  import b2s_pkg::*;
  logic [B2S_LEVEL_W-1:0] standby_level;
  logic standby_hi;
  logic [B2S_LEVEL_W-1:0] sleep_level;
  logic sleep_hi;
  logic [B2S_MODE_W-1:0] mode_code;
  logic turnoff_sleep;

  modport src (
    output standby_level, standby_hi, sleep_level, sleep_hi,
    output mode_code, turnoff_sleep
  );
  modport dst (
    input standby_level, standby_hi, sleep_level, sleep_hi,
    input mode_code, turnoff_sleep
  );
endinterface

`default_nettype wire

// [hw/b2s_otp_load.sv]
// One-shot loader: waits for the OTP image to be valid after reset
// and issues a single load pulse. Assumes otp_ready_i is on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none

module b2s_otp_load
  import b2s_pkg::*;
(
  input wire logic clk_sys_i,  // System clock
  input wire logic reset_i,    // Sync reset, high
  input wire logic otp_ready_i, // OTP image valid
  output logic load_o,         // One-cycle load pulse
  output logic loaded_o        // Load has happened
);

  b2s_load_state_t state_reg;
  b2s_load_state_t state_next;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      B2S_LD_WAIT: begin
        if (otp_ready_i) begin
          state_next = B2S_LD_LOAD;
        end
      end
      B2S_LD_LOAD: begin
        state_next = B2S_LD_DONE;
      end
      B2S_LD_DONE: begin
        state_next = B2S_LD_DONE;
      end
      default: begin
        state_next = B2S_LD_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_reg <= B2S_LD_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // [RULE_10] single load pulse
  assign load_o = (state_reg == B2S_LD_LOAD);
  assign loaded_o = (state_reg == B2S_LD_DONE);

endmodule

`default_nettype wire

// [hw/b2s_pkg.sv]
// Constants and types for the second buck regulator standby, sleep
// and switching mode register bank.
// Assumes one system clock and a byte-wide functional-page port.
//
// Functional notes
// [RULE_01] Three registers at consecutive functional addresses
// [RULE_02] Standby code bits 4:0 drive standby target
// [RULE_03] Standby content used only in standby
// [RULE_04] Sleep code bits 4:0 drive sleep target
// [RULE_05] Sleep register applies whenever regulator sleeps
// [RULE_06] Bit 5 picks low or high range
// [RULE_07] Mode bit 5 picks off or sleep
// [RULE_08] Mode bits 3:0 select switching mode
// [RULE_09] Reads and writes accepted at any time
// [RULE_10] Power-up values come from OTP memory; mode bit 5 has no OTP source and loads as 0
// [RULE_11] Bits 7:6, mode bit 4 read zero
// [RULE_12] Writes to unimplemented bits are ignored

package b2s_pkg;

  // ==========================================================
  // Register map
  localparam int B2S_DATA_W = 8;
  localparam int B2S_ADDR_W = 8;
  localparam int B2S_REG_COUNT = 3;
  localparam logic [7:0] B2S_ADDR_STANDBY = 8'h36;
  localparam logic [7:0] B2S_ADDR_SLEEP = 8'h37;
  localparam logic [7:0] B2S_ADDR_MODE = 8'h38;
  localparam logic [1:0] B2S_IDX_STANDBY = 2'h0;
  localparam logic [1:0] B2S_IDX_SLEEP = 2'h1;
  localparam logic [1:0] B2S_IDX_MODE = 2'h2;

  // ==========================================================
  // Field layout
  localparam int B2S_LEVEL_W = 5;
  localparam int B2S_LEVEL_LSB = 0;
  localparam int B2S_RANGE_BIT = 5;
  localparam int B2S_MODE_W = 4;
  localparam int B2S_MODE_LSB = 0;
  localparam int B2S_TURNOFF_BIT = 5;
  localparam logic [7:0] B2S_MASK_VOLT = 8'h3F;
  localparam logic [7:0] B2S_MASK_MODE = 8'h2F;
  localparam logic [7:0] B2S_RESET_VAL = 8'h00;
  localparam logic [7:0] B2S_READ_UNMAPPED = 8'h00;

  // ==========================================================
  // State encodings
  typedef enum logic [1:0] {
    B2S_REG_ON = 2'h0,
    B2S_REG_SLEEP = 2'h1,
    B2S_REG_OFF = 2'h2
  } b2s_reg_state_t;

  typedef enum logic [1:0] {
    B2S_LD_WAIT = 2'h0,
    B2S_LD_LOAD = 2'h1,
    B2S_LD_DONE = 2'h2
  } b2s_load_state_t;

endpackage

// [hw/b2s_regs.sv]
// Top of the buck 2 standby, sleep and switching mode register bank.
// Assumes the serial control port has already decoded a byte access
// and all inputs come from logic on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none

module b2s_regs
  import b2s_pkg::*;
(
  input wire logic clk_sys_i,          // System clock
  input wire logic reset_i,            // Sync reset, high
  input wire logic func_page_i,        // Functional page selected
  input wire logic [7:0] reg_addr_i,   // Register address
  input wire logic [7:0] reg_wdata_i,  // Write data
  input wire logic reg_wr_i,           // Write strobe
  input wire logic reg_rd_i,           // Read strobe
  output logic [7:0] reg_rdata_o,      // Read data
  output logic reg_rvalid_o,           // Read data valid
  output logic reg_hit_o,              // Last access mapped
  input wire logic otp_ready_i,        // OTP image valid
  input wire logic [5:0] otp_standby_i, // OTP standby value
  input wire logic [5:0] otp_sleep_i,  // OTP sleep value
  input wire logic [3:0] otp_mode_i,   // OTP mode code
  input wire logic sys_standby_i,      // System in standby
  input wire logic [4:0] run_level_i,  // Normal-run code
  input wire logic run_range_high_i,   // Normal-run range
  input wire logic turnoff_event_i,    // Turn-off pulse
  input wire logic turnon_event_i,     // Turn-on pulse
  output logic [4:0] buck2_target_level_o, // Applied code
  output logic buck2_range_high_o,     // Applied range
  output logic buck2_enable_o,         // Regulator on
  output logic buck2_sleeping_o,       // Regulator in sleep
  output logic [3:0] buck2_switch_mode_code_o, // Switching mode
  output logic buck2_turnoff_target_o, // 1: sleep after turn-off
  output logic otp_loaded_o            // Power-up load done
);

  // ==========================================================
  // Field masks
  function automatic logic [7:0] b2s_mask(input logic [1:0] idx);
    logic [7:0] m;
    m = B2S_MASK_VOLT;
    if (idx == B2S_IDX_MODE) begin
      m = B2S_MASK_MODE;
    end
    return m;
  endfunction

  // ==========================================================
  // Declarations
  b2s_cfg_if cfg ();
  logic otp_load;
  logic [7:0] bank_reg [B2S_REG_COUNT];
  logic [7:0] otp_val [B2S_REG_COUNT];
  logic [B2S_REG_COUNT-1:0] addr_hit;
  logic [B2S_REG_COUNT-1:0] wr_hit;
  logic any_hit;
  logic [7:0] rd_data_next;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic hit_reg;
  logic [7:0] mode_word;

  // ==========================================================
  // Power-up loader
  b2s_otp_load u_load (
    .clk_sys_i (clk_sys_i),
    .reset_i (reset_i),
    .otp_ready_i (otp_ready_i),
    .load_o (otp_load),
    .loaded_o (otp_loaded_o)
  );

  // Turn-off target has no OTP source; it powers up as off.
  assign mode_word = {4'h0, otp_mode_i};
  assign otp_val[B2S_IDX_STANDBY] = {2'h0, otp_standby_i};
  assign otp_val[B2S_IDX_SLEEP] = {2'h0, otp_sleep_i};
  assign otp_val[B2S_IDX_MODE] = mode_word;

  // ==========================================================
  // Address decode
  genvar gi;
  generate
    for (gi = 0; gi < B2S_REG_COUNT; gi++) begin : g_bank
      // [RULE_01] consecutive addresses
      assign addr_hit[gi] = func_page_i &&
        (reg_addr_i == B2S_ADDR_STANDBY + 8'(gi));
      // [RULE_09] no state condition
      assign wr_hit[gi] = reg_wr_i && addr_hit[gi];

      // Write after load wins, so software is never overwritten
      // by a late OTP image in the same cycle.
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          bank_reg[gi] <= B2S_RESET_VAL;
        end else if (wr_hit[gi]) begin
          // [RULE_12] unimplemented bits dropped
          bank_reg[gi] <= reg_wdata_i & b2s_mask(2'(gi));
        end else if (otp_load) begin
          // [RULE_10] load from OTP
          bank_reg[gi] <= otp_val[gi] & b2s_mask(2'(gi));
        end
      end
    end
  endgenerate

  assign any_hit = |addr_hit;

  // ==========================================================
  // Read path
  // [RULE_11] reserved bits stored as zero
  assign rd_data_next =
    addr_hit[B2S_IDX_STANDBY] ? bank_reg[B2S_IDX_STANDBY] :
    addr_hit[B2S_IDX_SLEEP] ? bank_reg[B2S_IDX_SLEEP] :
    addr_hit[B2S_IDX_MODE] ? bank_reg[B2S_IDX_MODE] :
    B2S_READ_UNMAPPED;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_reg <= B2S_READ_UNMAPPED;
      rvalid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_reg <= rd_data_next;
      end
      if (reg_rd_i || reg_wr_i) begin
        hit_reg <= any_hit;
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign reg_hit_o = hit_reg;

  // ==========================================================
  // Field extraction
  // [RULE_02] standby code low bits
  assign cfg.standby_level =
    bank_reg[B2S_IDX_STANDBY][B2S_LEVEL_LSB +: B2S_LEVEL_W];
  // [RULE_06] range bit
  assign cfg.standby_hi = bank_reg[B2S_IDX_STANDBY][B2S_RANGE_BIT];
  // [RULE_04] sleep code low bits
  assign cfg.sleep_level =
    bank_reg[B2S_IDX_SLEEP][B2S_LEVEL_LSB +: B2S_LEVEL_W];
  assign cfg.sleep_hi = bank_reg[B2S_IDX_SLEEP][B2S_RANGE_BIT];
  // [RULE_08] switching mode code
  assign cfg.mode_code =
    bank_reg[B2S_IDX_MODE][B2S_MODE_LSB +: B2S_MODE_W];
  // [RULE_07] turn-off target bit
  assign cfg.turnoff_sleep = bank_reg[B2S_IDX_MODE][B2S_TURNOFF_BIT];

  assign buck2_switch_mode_code_o = cfg.mode_code;
  assign buck2_turnoff_target_o = cfg.turnoff_sleep;

  // ==========================================================
  // Target selection
  b2s_target_sel u_sel (
    .clk_sys_i (clk_sys_i),
    .reset_i (reset_i),
    .cfg (cfg.dst),
    .sys_standby_i (sys_standby_i),
    .run_level_i (run_level_i),
    .run_range_high_i (run_range_high_i),
    .turnoff_event_i (turnoff_event_i),
    .turnon_event_i (turnon_event_i),
    .target_level_o (buck2_target_level_o),
    .range_high_o (buck2_range_high_o),
    .enable_o (buck2_enable_o),
    .sleeping_o (buck2_sleeping_o)
  );

endmodule

`default_nettype wire

// [hw/b2s_target_sel.sv]
// Regulator state tracking and target selection for buck 2.
// Assumes the normal-run level comes from a register outside.
`timescale 1ns/1ns
`default_nettype none

module b2s_target_sel
  import b2s_pkg::*;
(
  input wire logic clk_sys_i,          // System clock
  input wire logic reset_i,            // Sync reset, high
  b2s_cfg_if.dst cfg,                  // Register fields
  input wire logic sys_standby_i,      // System in standby
  input wire logic [4:0] run_level_i,  // Normal-run code
  input wire logic run_range_high_i,   // Normal-run range
  input wire logic turnoff_event_i,    // Turn-off pulse
  input wire logic turnon_event_i,     // Turn-on pulse
  output logic [4:0] target_level_o,   // Applied code
  output logic range_high_o,           // Applied range
  output logic enable_o,               // Regulator on
  output logic sleeping_o              // Regulator in sleep
);

  b2s_reg_state_t state_reg;
  b2s_reg_state_t state_next;
  logic [B2S_LEVEL_W-1:0] level_next;
  logic range_next;

  // ==========================================================
  // Regulator state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      B2S_REG_ON: begin
        // [RULE_07] turn-off destination
        if (turnoff_event_i) begin
          state_next = cfg.turnoff_sleep ? B2S_REG_SLEEP : B2S_REG_OFF;
        end
      end
      B2S_REG_SLEEP: begin
        if (turnon_event_i && !turnoff_event_i) begin
          state_next = B2S_REG_ON;
        end
      end
      B2S_REG_OFF: begin
        if (turnon_event_i && !turnoff_event_i) begin
          state_next = B2S_REG_ON;
        end
      end
      default: begin
        state_next = B2S_REG_OFF;
      end
    endcase
  end

  // ==========================================================
  // Target selection
  // [RULE_05] sleep register while sleeping
  // [RULE_03] standby only in standby
  assign level_next = (state_reg == B2S_REG_SLEEP) ? cfg.sleep_level :
                      sys_standby_i ? cfg.standby_level : run_level_i;
  // [RULE_06] range follows selected code
  assign range_next = (state_reg == B2S_REG_SLEEP) ? cfg.sleep_hi :
                      sys_standby_i ? cfg.standby_hi : run_range_high_i;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_reg <= B2S_REG_ON;
      target_level_o <= '0;
      range_high_o <= 1'b0;
      enable_o <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      target_level_o <= level_next;
      range_high_o <= range_next;
      enable_o <= (state_reg != B2S_REG_OFF);
      sleeping_o <= (state_reg == B2S_REG_SLEEP);
    end
  end

endmodule

`default_nettype wire

// [verification/b2s_regs_asserts.sv]
// Assertions on the buck 2 register bank top ports.
// Assumes a bind from the bench top and one clock domain.
`timescale 1ns/1ns
`default_nettype none

module b2s_regs_asserts
  import b2s_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic func_page_i, // Page
  input wire logic [7:0] reg_addr_i, // Address
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write
  input wire logic reg_rd_i, // Read
  input wire logic [7:0] reg_rdata_o, // Read data
  input wire logic reg_rvalid_o, // Read valid
  input wire logic reg_hit_o, // Mapped
  input wire logic [3:0] otp_mode_i, // OTP mode
  input wire logic sys_standby_i, // Standby
  input wire logic [4:0] run_level_i, // Run code
  input wire logic run_range_high_i, // Run range
  input wire logic [4:0] buck2_target_level_o, // Code
  input wire logic buck2_range_high_o, // Range
  input wire logic buck2_enable_o, // On
  input wire logic buck2_sleeping_o, // Sleep
  input wire logic [3:0] buck2_switch_mode_code_o, // Mode
  input wire logic buck2_turnoff_target_o, // Off target
  input wire logic otp_loaded_o // Loaded
);
  // ====
  // Properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic [7:0] wd_q;
  wire map_a = func_page_i && reg_addr_i >= B2S_ADDR_STANDBY &&
    reg_addr_i <= B2S_ADDR_MODE;
  wire mode_a = func_page_i && reg_addr_i == B2S_ADDR_MODE;
  always_ff @(posedge clk_sys_i) begin
    wd_q <= reg_wdata_i;
  end
  property p_rd_lat;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("no read valid");
  property p_rv_one;
    !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rv_one: assert property (p_rv_one) else $error("stray valid");
  property p_unmap;
    reg_rd_i && !map_a |=> reg_rdata_o == 8'h00 && !reg_hit_o;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_top_zero;
    reg_rvalid_o |-> reg_rdata_o[7:6] == 2'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("top bits");
  property p_mode_b4;
    reg_rd_i && mode_a |=> reg_rdata_o[4] == 1'b0 && reg_hit_o;
  endproperty
  a_mode_b4: assert property (p_mode_b4) else $error("mode bit 4");
  property p_mode_wr;
    reg_wr_i && mode_a |=> buck2_switch_mode_code_o == wd_q[3:0] &&
      buck2_turnoff_target_o == wd_q[5];
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode write");
  property p_off_tgt;
    $rose(buck2_sleeping_o) |-> $past(buck2_turnoff_target_o);
  endproperty
  a_off_tgt: assert property (p_off_tgt) else $error("bad sleep");
  property p_sleep_en;
    buck2_sleeping_o |-> buck2_enable_o;
  endproperty
  a_sleep_en: assert property (p_sleep_en) else $error("sleep off");
  property p_run;
    !$past(reset_i) && !buck2_sleeping_o && !$past(sys_standby_i) |->
      buck2_target_level_o == $past(run_level_i) &&
      buck2_range_high_o == $past(run_range_high_i);
  endproperty
  a_run: assert property (p_run) else $error("run target");
  property p_otp;
    $rose(otp_loaded_o) |-> buck2_switch_mode_code_o == $past(otp_mode_i)
      && !buck2_turnoff_target_o;
  endproperty
  a_otp: assert property (p_otp) else $error("otp load");
  c_sleep: cover property ($rose(buck2_sleeping_o));
  c_off: cover property ($fell(buck2_enable_o));
  c_read: cover property (reg_rvalid_o && reg_hit_o);
endmodule

`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the buck 2 register bank.
// Assumes the checker is bound here; bench drives on falling edges.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import b2s_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic page = 1'b1, wr = 1'b0, rd = 1'b0, rdy = 1'b0, stby = 1'b0;
  logic toff = 1'b0, ton = 1'b0, rhi = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdata;
  logic [4:0] rlev = 5'h00, tlev;
  logic [5:0] ostb = 6'h2B, oslp = 6'h15;
  logic [3:0] omode = 4'hA, smode;
  logic rvalid, hit, thi, en, slp, ttgt, loaded;
  int fail_count = 0, n_compared = 0, cyc = 0;

  b2s_regs i_b2s_regs (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .func_page_i(page),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .reg_hit_o(hit), .otp_ready_i(rdy), .otp_standby_i(ostb),
    .otp_sleep_i(oslp), .otp_mode_i(omode), .sys_standby_i(stby),
    .run_level_i(rlev), .run_range_high_i(rhi),
    .turnoff_event_i(toff), .turnon_event_i(ton),
    .buck2_target_level_o(tlev), .buck2_range_high_o(thi),
    .buck2_enable_o(en), .buck2_sleeping_o(slp),
    .buck2_switch_mode_code_o(smode),
    .buck2_turnoff_target_o(ttgt), .otp_loaded_o(loaded)
  );

  always #5 clk_sys_i = !clk_sys_i;
  // Ceiling well above the hundred or so cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end

  // ====
  // Shared tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_i);
    rd = 1'b0;
    // Valid stands for one cycle only, so look now
    chk({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask
  task automatic ev(input logic off);
    @(negedge clk_sys_i);
    toff = off;
    ton = !off;
    @(negedge clk_sys_i);
    toff = 1'b0;
    ton = 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ====
  // Scenarios
  task automatic t_otp();
    logic [7:0] d;
    rd_reg(B2S_ADDR_MODE, d);
    chk(d, 8'h00);
    rdy = 1'b1;
    for (int i = 0; i < 20 && loaded !== 1'b1; i++) @(negedge clk_sys_i);
    chk({7'h00, loaded}, 8'h01);
    rd_reg(B2S_ADDR_STANDBY, d);
    chk(d, {2'h0, ostb});
    rd_reg(B2S_ADDR_SLEEP, d);
    chk(d, {2'h0, oslp});
    rd_reg(B2S_ADDR_MODE, d);
    chk(d, {4'h0, omode});
    $display("otp test done");
  endtask
  task automatic t_mask();
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      wr_reg(B2S_ADDR_STANDBY + 8'(i), 8'hFF);
      rd_reg(B2S_ADDR_STANDBY + 8'(i), d);
      chk(d, (i == 2) ? 8'h2F : 8'h3F);
      chk({7'h00, hit}, 8'h01);
    end
    chk({3'h0, ttgt, smode}, 8'h1F);
    wr_reg(B2S_ADDR_MODE, 8'hD0);
    rd_reg(B2S_ADDR_MODE, d);
    chk(d, 8'h00);
    page = 1'b0;
    wr_reg(B2S_ADDR_STANDBY, 8'h00);
    rd_reg(B2S_ADDR_STANDBY, d);
    chk({d[6:0], hit}, 8'h00);
    page = 1'b1;
    rd_reg(B2S_ADDR_STANDBY, d);
    chk(d, 8'h3F);
    rd_reg(8'h35, d);
    chk({d[6:0], hit}, 8'h00);
    rd_reg(8'h39, d);
    chk({d[6:0], hit}, 8'h00);
    $display("mask test done");
  endtask
  task automatic t_run();
    wr_reg(B2S_ADDR_STANDBY, 8'h33);
    rlev = 5'h0A;
    repeat (3) @(negedge clk_sys_i);
    chk({2'h0, thi, tlev}, 8'h0A);
    stby = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk({2'h0, thi, tlev}, 8'h33);
    $display("run test done");
  endtask
  task automatic t_sleep();
    wr_reg(B2S_ADDR_SLEEP, 8'h0C);
    wr_reg(B2S_ADDR_MODE, 8'h25);
    ev(1'b1);
    chk({6'h0, en, slp}, 8'h03);
    chk({2'h0, thi, tlev}, 8'h0C);
    wr_reg(B2S_ADDR_SLEEP, 8'h31);
    repeat (2) @(negedge clk_sys_i);
    chk({2'h0, thi, tlev}, 8'h31);
    ev(1'b0);
    chk({6'h0, en, slp}, 8'h02);
    wr_reg(B2S_ADDR_MODE, 8'h05);
    ev(1'b1);
    chk({6'h0, en, slp}, 8'h00);
    ev(1'b0);
    stby = 1'b0;
    $display("sleep test done");
  endtask
  task automatic t_reset();
    logic [7:0] d;
    @(negedge clk_sys_i);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk({5'h00, en, slp, loaded}, 8'h00);
    chk(rdata, 8'h00);
    reset_i = 1'b0;
    for (int i = 0; i < 20 && loaded !== 1'b1; i++) @(negedge clk_sys_i);
    chk({7'h00, loaded}, 8'h01);
    rd_reg(B2S_ADDR_MODE, d);
    chk(d, {4'h0, omode});
    rd_reg(B2S_ADDR_SLEEP, d);
    chk(d, {2'h0, oslp});
    $display("reset test done");
  endtask

  initial begin
    repeat (12) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_otp();
    t_mask();
    t_run();
    t_sleep();
    t_reset();
    final_report();
  end
endmodule

bind b2s_regs b2s_regs_asserts i_b2s_regs_asserts (.*);

`default_nettype wire
